//--- uhtf_regs.sv
// Token, frame number and frame-end guard registers of a full-speed USB controller
// Function
// RULE1: Frame number low byte, read-only, resets zero
// RULE2: Frame number upper three bits, read-only
// RULE3: Received start-of-frame loads both frame fields
// RULE4: Upper frame register bits 31-3 read zero
// RULE5: Packet type bits 7-4: OUT, IN, SETUP
// RULE6: Software writes only the three packet codes
// RULE7: Software writes valid endpoint in bits 3-0
// RULE8: Eight-bit read/write guard count, resets zero
// RULE9: Recommended guard counts for 64/32/16 bytes
// RULE10: Recommended guard count for 8-byte packets
// RULE11: Software checks busy before new token
// RULE12: Host sends start-of-frame every millisecond
// RULE13: Slow select picks speed of next token
// RULE14: Token write starts transaction, sets busy
// RULE15: No new token when frame time short
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module uhtf_regs #(
    parameter int FRAME_CYCLES = uhtf_pkg::FRAME_CYCLES, // Cycles per 1 ms frame
    parameter int GUARD_UNIT = uhtf_pkg::GUARD_UNIT_CYCLES // Cycles per guard unit
) (
    input wire logic i_sys_clk, // 100 MHz clock
    input wire logic i_rstn, // Async reset, active low
    input wire logic [7:0] i_avs_address, // Byte address
    input wire logic i_avs_read, // Read request
    input wire logic i_avs_write, // Write request
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [3:0] i_avs_byteenable, // Byte enables
    output logic [31:0] o_avs_readdata, // Read data, registered
    output logic o_avs_waitrequest, // Stall until answer ready
    input wire logic i_sof_rx, // Pulse: start-of-frame token received
    input wire logic [10:0] i_sof_rx_frame, // Frame number in that token
    output logic o_tok_start, // Pulse: launch token on the bus
    output logic [3:0] o_tok_pid, // Packet type of launched token
    output logic [3:0] o_tok_endpoint, // Endpoint of launched token
    output logic o_tok_slow, // Token to run at low speed
    input wire logic i_tok_done, // Pulse: bus transaction completed
    output logic o_sof_tx, // Pulse: send start-of-frame token
    output logic [10:0] o_sof_tx_frame // Frame number to send
);
    typedef enum logic [1:0] {
        UHTF_IDLE = 2'b00,
        UHTF_WAIT = 2'b01,
        UHTF_BUSY = 2'b11
    } uhtf_tok_e;

    // Decode of an aligned word offset
    function automatic logic uhtf_hit(input logic [7:0] addr, input logic [7:0] off);
        uhtf_hit = (addr[7:2] == off[7:2]);
    endfunction : uhtf_hit

    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] frame_lo_reg, frame_lo_next;
    logic [2:0] frame_hi_reg, frame_hi_next;
    logic [7:0] tok_reg, tok_next;
    logic [7:0] guard_reg, guard_next;
    logic [2:0] ctrl_reg, ctrl_next;
    uhtf_tok_e st_reg, st_next;
    logic start_reg, start_next;
    logic slow_reg, slow_next;
    logic [10:0] tx_frame_reg, tx_frame_next;
    logic sof_tick;
    logic [31:0] frame_left;
    logic wr_en, rd_en, busy, host_on, sof_on, room_ok;
    logic [31:0] guard_cycles;

    assign host_on = ctrl_reg[uhtf_pkg::CTRL_HOST_BIT];
    assign sof_on = ctrl_reg[uhtf_pkg::CTRL_SOF_BIT];
    assign busy = (st_reg != UHTF_IDLE);

    // One-cycle stall then answer; write takes effect on the ack edge
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
    assign wr_en = i_avs_write & ack_reg;
    assign rd_en = i_avs_read & ~ack_reg;

    // Frame timer, runs only while the host generates frames
    uhtf_cnt #(
        .PERIOD(FRAME_CYCLES)
    ) u_cnt (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_run(host_on & sof_on),
        .o_tick(sof_tick),
        .o_left(frame_left)
    );

    // Guard converted to cycles; product fits easily in 32 bits
    assign guard_cycles = 32'(guard_reg) * 32'(GUARD_UNIT);
    // Without frame generation there is no frame end to protect
    assign room_ok = ~(host_on & sof_on) | (frame_left >= guard_cycles); // RULE15

    // Bus handshake and read mux
    always_comb begin
        ack_next = (i_avs_read | i_avs_write) & ~ack_reg;
        rdata_next = rdata_reg;
        if (rd_en) begin
            rdata_next = 32'h0000_0000;
            if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_FRAME_NUMBER_LOW)) begin
                rdata_next[7:0] = frame_lo_reg; // RULE1
            end else if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_FRAME_NUMBER_HIGH)) begin
                rdata_next[2:0] = frame_hi_reg; // RULE2 RULE4
            end else if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_TOKEN_COMMAND)) begin
                rdata_next[7:0] = tok_reg;
            end else if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_FRAME_END_THRESHOLD)) begin
                rdata_next[7:0] = guard_reg; // RULE8
            end else if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_LINK_CONTROL)) begin
                rdata_next[2:0] = ctrl_reg;
            end else if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_LINK_STATUS)) begin
                rdata_next[uhtf_pkg::STAT_BUSY_BIT] = busy;
            end
        end
    end

    // Software-written registers; frame fields follow the link
    always_comb begin
        guard_next = guard_reg;
        ctrl_next = ctrl_reg;
        frame_lo_next = frame_lo_reg;
        frame_hi_next = frame_hi_reg;
        tx_frame_next = tx_frame_reg;
        if (wr_en && i_avs_byteenable[0]) begin
            if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_FRAME_END_THRESHOLD)) begin
                guard_next = i_avs_writedata[7:0]; // RULE8 RULE9 RULE10
            end
            if (uhtf_hit(i_avs_address, uhtf_pkg::OFF_LINK_CONTROL)) begin
                ctrl_next = i_avs_writedata[2:0];
            end
        end
        if (i_sof_rx) begin
            frame_lo_next = i_sof_rx_frame[7:0]; // RULE3
            frame_hi_next = i_sof_rx_frame[10:8]; // RULE3
        end
        if (sof_tick) begin
            tx_frame_next = tx_frame_reg + 11'h001; // RULE12
        end
        // Toggling host role clears the host frame counter
        if (ctrl_next[uhtf_pkg::CTRL_HOST_BIT] != host_on) begin
            tx_frame_next = uhtf_pkg::RESET_FRAME;
        end
    end

    // Token state: a write waits for room, then launches and stays busy to completion
    always_comb begin
        tok_next = tok_reg;
        st_next = st_reg;
        start_next = 1'b0;
        slow_next = slow_reg;
        unique case (st_reg)
            UHTF_IDLE: begin
                // Writes while busy are dropped; software must poll first
                if (wr_en && i_avs_byteenable[0] && uhtf_hit(i_avs_address, uhtf_pkg::OFF_TOKEN_COMMAND)) begin
                    tok_next = i_avs_writedata[7:0]; // RULE5 RULE6 RULE7 RULE11
                    slow_next = ctrl_reg[uhtf_pkg::CTRL_SLOW_BIT]; // RULE13
                    st_next = UHTF_WAIT; // RULE14
                end
            end
            UHTF_WAIT: begin
                if (room_ok) begin
                    start_next = 1'b1; // RULE14 RULE15
                    st_next = UHTF_BUSY;
                end
            end
            UHTF_BUSY: begin
                if (i_tok_done && !start_reg) begin
                    st_next = UHTF_IDLE; // RULE14
                end
            end
            default: begin
                st_next = UHTF_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            frame_lo_reg <= uhtf_pkg::RESET_BYTE;
            frame_hi_reg <= 3'h0;
            tok_reg <= uhtf_pkg::RESET_BYTE;
            guard_reg <= uhtf_pkg::RESET_BYTE;
            ctrl_reg <= 3'h0;
            st_reg <= UHTF_IDLE;
            start_reg <= 1'b0;
            slow_reg <= 1'b0;
            tx_frame_reg <= uhtf_pkg::RESET_FRAME;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            frame_lo_reg <= frame_lo_next;
            frame_hi_reg <= frame_hi_next;
            tok_reg <= tok_next;
            guard_reg <= guard_next;
            ctrl_reg <= ctrl_next;
            st_reg <= st_next;
            start_reg <= start_next;
            slow_reg <= slow_next;
            tx_frame_reg <= tx_frame_next;
        end
    end

    assign o_avs_readdata = rdata_reg;
    assign o_tok_start = start_reg;
    assign o_tok_pid = tok_reg[uhtf_pkg::PID_LSB +: 4];
    assign o_tok_endpoint = tok_reg[uhtf_pkg::EP_LSB +: 4];
    assign o_tok_slow = slow_reg;
    assign o_sof_tx = sof_tick; // RULE12
    assign o_sof_tx_frame = tx_frame_reg;
endmodule : uhtf_regs

//--- uhtf_pkg.sv
// Package with register map, field layout, codes and timing for the token/frame register block
package uhtf_pkg;
    // Register byte offsets (word aligned)
    localparam logic [7:0] OFF_FRAME_NUMBER_LOW = 8'h00;
    localparam logic [7:0] OFF_FRAME_NUMBER_HIGH = 8'h04;
    localparam logic [7:0] OFF_TOKEN_COMMAND = 8'h08;
    localparam logic [7:0] OFF_FRAME_END_THRESHOLD = 8'h0C;
    localparam logic [7:0] OFF_LINK_CONTROL = 8'h10;
    localparam logic [7:0] OFF_LINK_STATUS = 8'h14;
    // Field positions
    localparam int PID_LSB = 4;
    localparam int EP_LSB = 0;
    localparam int FRAME_HIGH_W = 3;
    localparam int CTRL_HOST_BIT = 0;
    localparam int CTRL_SOF_BIT = 1;
    localparam int CTRL_SLOW_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [10:0] RESET_FRAME = 11'h000;
    // Packet type codes
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hD;
    // Recommended guard counts per packet size
    localparam logic [7:0] GUARD_64 = 8'h4A;
    localparam logic [7:0] GUARD_32 = 8'h2A;
    localparam logic [7:0] GUARD_16 = 8'h1A;
    localparam logic [7:0] GUARD_8 = 8'h12;
    // Frame period
    localparam int CLK_MHZ = 100;
    localparam int FRAME_US = 1000;
    localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
    // One guard-count unit in system clocks (one full-speed byte time, about 667 ns)
    localparam int GUARD_UNIT_CYCLES = 67;
endpackage : uhtf_pkg

//--- uhtf_cnt.sv
// Frame-period down counter with start-of-frame strobe
`timescale 1ns/1ns
module uhtf_cnt #(
    parameter int PERIOD = uhtf_pkg::FRAME_CYCLES
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rstn, // Async reset, active low
    input wire logic i_run, // Count enable level
    output logic o_tick, // One-cycle strobe at frame start
    output logic [31:0] o_left // Cycles left in frame
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    // Reload at zero; holds at full period while stopped
    always_comb begin
        tick_next = 1'b0;
        if (!i_run) begin
            cnt_next = 32'(PERIOD - 1);
        end else if (cnt_reg == 32'h0000_0000) begin
            cnt_next = 32'(PERIOD - 1);
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg - 32'h0000_0001;
        end
    end

    // State registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign o_tick = tick_reg;
    assign o_left = cnt_reg;
endmodule : uhtf_cnt

//--- uhtf_chk.sv
// Assertion checker for the token and frame register block, bound to its ports
`timescale 1ns/1ns
module uhtf_chk #(
    parameter int FRAME_CYCLES = 200
) (
    input wire logic i_sys_clk, // Clock
    input wire logic i_rstn, // Reset, active low
    input wire logic [7:0] i_avs_address, // Address
    input wire logic i_avs_read, // Read
    input wire logic i_avs_write, // Write
    input wire logic [31:0] o_avs_readdata, // Read data
    input wire logic o_avs_waitrequest, // Stall
    input wire logic o_tok_start, // Token launch
    input wire logic [3:0] o_tok_pid, // Packet type
    input wire logic [3:0] o_tok_endpoint, // Endpoint
    input wire logic o_sof_tx, // Frame start strobe
    input wire logic [10:0] o_sof_tx_frame // Host frame number
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    logic rd_ok;
    logic seen_reg;
    logic [31:0] gap_reg;
    // Answer cycle of a read, where read data stand
    assign rd_ok = i_avs_read && !o_avs_waitrequest;
    // Cycles since the last strobe; the first strobe has no reference and is skipped
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gap_reg <= 32'h0000_0000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= o_sof_tx ? 32'h0000_0000 : gap_reg + 32'h0000_0001;
            seen_reg <= seen_reg | o_sof_tx;
        end
    end
    a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer not after one wait state");
    a_idle_free: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait raised without request");
    a_low_bits: assert property (rd_ok && i_avs_address[7:2] == 6'h00 |-> o_avs_readdata[31:8] == 24'h00_0000)
        else $error("frame low word has upper bits set");
    a_high_bits: assert property (rd_ok && i_avs_address[7:2] == 6'h01 |-> o_avs_readdata[31:3] == 29'h0)
        else $error("frame high word bits above 2 set");
    a_guard_byte: assert property (rd_ok && i_avs_address[7:2] == 6'h03 |-> o_avs_readdata[31:8] == 24'h00_0000)
        else $error("guard word has upper bits set");
    a_start_gap: assert property (o_tok_start |=> !o_tok_start [*3])
        else $error("token launches too close");
    a_start_fields: assert property (o_tok_start |-> $stable(o_tok_pid) && $stable(o_tok_endpoint))
        else $error("token fields moved at launch");
    a_sof_period: assert property (o_sof_tx && seen_reg |-> gap_reg == FRAME_CYCLES - 1)
        else $error("frame start period wrong");
    a_sof_count: assert property (o_sof_tx |=> o_sof_tx_frame == $past(o_sof_tx_frame) + 11'h001)
        else $error("host frame number did not advance");
endmodule : uhtf_chk
bind uhtf_regs uhtf_chk #(.FRAME_CYCLES(FRAME_CYCLES)) uhtf_chk_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_tok_start(o_tok_start),
    .o_tok_pid(o_tok_pid), .o_tok_endpoint(o_tok_endpoint), .o_sof_tx(o_sof_tx), .o_sof_tx_frame(o_sof_tx_frame));

//--- uhtf_usb_model.sv
// Behavioural model of the bus side: ends token transactions and reports received frame starts
`timescale 1ns/1ns
module uhtf_usb_model (
    input wire logic i_sys_clk, // Clock
    input wire logic i_rstn, // Reset, active low
    input wire logic i_tok_start, // Token launch
    input wire logic [7:0] i_delay, // Transaction length
    input wire logic i_send, // Make a frame start
    input wire logic [10:0] i_frame, // Its frame number
    output logic o_tok_done, // Transaction over
    output logic o_sof_rx, // Frame start seen
    output logic [10:0] o_sof_rx_frame // Frame number
);
    logic busy_reg;
    logic [7:0] cnt_reg;
    // Done only after a launch; frame lines flip outside the pulse so stale data cannot pass
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            o_tok_done <= 1'b0;
            o_sof_rx <= 1'b0;
            o_sof_rx_frame <= 11'h000;
        end else begin
            o_tok_done <= busy_reg && cnt_reg == 8'h00;
            if (i_tok_start) begin
                busy_reg <= 1'b1;
                cnt_reg <= i_delay;
            end else if (cnt_reg == 8'h00) busy_reg <= 1'b0;
            else cnt_reg <= cnt_reg - 8'h01;
            o_sof_rx <= i_send;
            o_sof_rx_frame <= i_send ? i_frame : ~o_sof_rx_frame;
        end
    end
endmodule : uhtf_usb_model

//--- tb.sv
// Self-checking testbench for the token and frame register block
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, snd = 1'b0, ts, tl, td, sr, st, wq;
    logic [7:0] adr = 8'h00, dly = 8'h10;
    logic [31:0] wd = 32'h0000_0000, q, rv;
    logic [3:0] be = 4'hF, tp, te;
    logic [10:0] sf, stf, frm = 11'h000;
    logic [15:0] lf = 16'h0038;
    int n_errors = 0, samples_checked = 0, n_start = 0, since = 0, seen = 0;
    always #5 clk = ~clk;
    uhtf_regs #(.FRAME_CYCLES(200), .GUARD_UNIT(1)) uhtf_regs_inst (.i_sys_clk(clk), .i_rstn(rstn),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(q), .o_avs_waitrequest(wq), .i_sof_rx(sr), .i_sof_rx_frame(sf), .o_tok_start(ts),
        .o_tok_pid(tp), .o_tok_endpoint(te), .o_tok_slow(tl), .i_tok_done(td), .o_sof_tx(st), .o_sof_tx_frame(stf));
    uhtf_usb_model uhtf_usb_model_inst (.i_sys_clk(clk), .i_rstn(rstn), .i_tok_start(ts), .i_delay(dly),
        .i_send(snd), .i_frame(frm), .o_tok_done(td), .o_sof_rx(sr), .o_sof_rx_frame(sf));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    task automatic fail(input string m);
        n_errors++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask : fail
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("got %h expected %h", g, e));
    endtask : chk
    task automatic final_report();
        $display("Errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    // Master holds the request until the rising edge that sees the stall low, takes data there, then releases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        adr <= a; rd <= !w; wr <= w; wd <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wq === 1'b0) break;
        end
        if (i == 20) begin fail("bus timeout"); final_report(); end
        rv = q;
        rd <= 1'b0; wr <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rv, e);
    endtask : rdc
    // Launch count and frame position, so late launches can be caught
    always @(posedge clk) begin
        since <= st ? 0 : since + 1;
        seen <= seen | st;
        if (ts === 1'b1) n_start <= n_start + 1;
        if (ts === 1'b1 && seen != 0 && since + 74 > 202) fail("token launched inside guard");
    end
    initial begin
        int i, k;
        logic [7:0] g[5];
        logic [3:0] p[3];
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 7; k++) rdc(8'(k * 4), 32'h0000_0000);
        // Writes to read-only and unmapped words are dropped
        bus(1'b1, uhtf_pkg::OFF_FRAME_NUMBER_LOW, 32'hFFFF_FFFF);
        bus(1'b1, 8'h18, 32'hFFFF_FFFF);
        rdc(uhtf_pkg::OFF_FRAME_NUMBER_LOW, 32'h0000_0000);
        rdc(8'h18, 32'h0000_0000);
        // Received frame numbers: all-ones corner, then random
        for (k = 0; k < 4; k++) begin
            lf = nx(lf);
            @(posedge clk);
            snd <= 1'b1;
            frm <= (k == 0) ? 11'h7FF : lf[10:0];
            @(posedge clk);
            snd <= 1'b0;
            rdc(uhtf_pkg::OFF_FRAME_NUMBER_LOW, {24'h00_0000, frm[7:0]});
            rdc(uhtf_pkg::OFF_FRAME_NUMBER_HIGH, {29'h0000_0000, frm[10:8]});
        end
        g = '{uhtf_pkg::GUARD_64, uhtf_pkg::GUARD_32, uhtf_pkg::GUARD_16, uhtf_pkg::GUARD_8, lf[15:8]};
        for (k = 0; k < 5; k++) begin
            bus(1'b1, uhtf_pkg::OFF_FRAME_END_THRESHOLD, {24'hA5_5A5A, g[k]});
            rdc(uhtf_pkg::OFF_FRAME_END_THRESHOLD, {24'h00_0000, g[k]});
        end
        be <= 4'hE;
        bus(1'b1, uhtf_pkg::OFF_FRAME_END_THRESHOLD, 32'h0000_0000);
        be <= 4'hF;
        rdc(uhtf_pkg::OFF_FRAME_END_THRESHOLD, {24'h00_0000, g[4]});
        // Tokens of every type; the last three run in host mode, two of them late in the frame
        p = '{uhtf_pkg::PID_OUT, uhtf_pkg::PID_IN, uhtf_pkg::PID_SETUP};
        for (k = 0; k < 9; k++) begin
            lf = nx(lf);
            if (k == 6) bus(1'b1, uhtf_pkg::OFF_FRAME_END_THRESHOLD, {24'h00_0000, uhtf_pkg::GUARD_64});
            bus(1'b1, uhtf_pkg::OFF_LINK_CONTROL, {29'h0000_0000, k[0], k >= 6, k >= 6});
            if (k >= 7) for (i = 0; i < 300 && since != 130; i++) @(posedge clk);
            dly <= 8'h10 + {4'h0, lf[3:0]};
            bus(1'b1, uhtf_pkg::OFF_TOKEN_COMMAND, {24'h00_0000, p[k % 3], lf[7:4]});
            bus(1'b1, uhtf_pkg::OFF_TOKEN_COMMAND, 32'h0000_00D0);
            rdc(uhtf_pkg::OFF_LINK_STATUS, 32'h0000_0001);
            for (i = 0; i < 150; i++) begin
                bus(1'b0, uhtf_pkg::OFF_LINK_STATUS, 32'h0000_0000);
                if (rv === 32'h0000_0000) break;
            end
            if (i == 150) begin fail("token never finished"); final_report(); end
            chk(n_start, k + 1);
            chk({23'h00_0000, tl, tp, te}, {23'h00_0000, k[0], p[k % 3], lf[7:4]});
            rdc(uhtf_pkg::OFF_TOKEN_COMMAND, {24'h00_0000, p[k % 3], lf[7:4]});
        end
        final_report();
    end
endmodule : tb
